/* File: dv/flash_command_host_sva.sv */
// concurrent checks on the flash command host ports
`timescale 1ns/1ps
module flash_command_host_sva #(
    parameter int RECOVER_CYCLES = 20
) (
    // clock and reset
    input wire logic                  clock,
    input wire logic                  rstn,
    // user side
    input wire logic                  reqValid,
    input wire logic                  reqReady,
    input wire flash_host_pkg::req_s  req,
    input wire logic                  rspValid,
    input wire flash_host_pkg::rsp_s  rsp,
    // flash pins
    input wire flash_host_pkg::pins_s pins,
    input wire logic [15:0]           flashDataIn
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // ============================================================
    // cycles the strobe has been high since its last low phase
    int weHighCnt_ff;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) weHighCnt_ff <= 100000;
        else if (!pins.weN) weHighCnt_ff <= 0;
        else if (weHighCnt_ff < 100000) weHighCnt_ff <= weHighCnt_ff + 1;
    end

    // ============================================================
    // properties
    AST_WRITE_PINS: assert property (!pins.weN |-> !pins.selN && pins.oeN && pins.supplyHigh)
        else $error("write strobe without select, oe high and supply");
    AST_READ_PINS: assert property (!pins.oeN |-> !pins.selN && pins.weN)
        else $error("output enable without select or with strobe");
    AST_NO_CONTENTION: assert property (pins.dataOe |-> pins.oeN && !pins.selN)
        else $error("host drives data while device may drive");
    AST_STROBE_LOW: assert property ($fell(pins.weN) |-> !pins.weN [*5])
        else $error("write strobe low phase too short");
    AST_STROBE_HIGH: assert property ($rose(pins.weN) |-> pins.weN [*3])
        else $error("write strobe high phase too short");
    AST_SUPPLY_FIRST: assert property ($fell(pins.weN) |-> $past(pins.supplyHigh))
        else $error("strobe fell before program supply was raised");
    AST_WRITE_RECOVER: assert property ($fell(pins.oeN) |-> weHighCnt_ff >= RECOVER_CYCLES)
        else $error("read began too soon after a write");
    AST_LATCH_STABLE: assert property (!pins.weN |=> $stable(pins.addr) && $stable(pins.dataOut))
        else $error("address or data moved during the strobe");
    AST_IDLE_QUIET: assert property (reqReady |-> pins.selN && pins.weN && pins.oeN && !pins.dataOe)
        else $error("pins active while host idle");
    AST_RSP_PULSE: assert property (rspValid |=> !rspValid && reqReady)
        else $error("answer pulse longer than one cycle");
    COV_FAIL: cover property (rspValid && rsp.fail);
endmodule : flash_command_host_sva

bind flash_command_host flash_command_host_sva #(.RECOVER_CYCLES(RECOVER_CYCLES)) u_sva (
    .clock(clock), .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady), .req(req),
    .rspValid(rspValid), .rsp(rsp), .pins(pins), .flashDataIn(flashDataIn));

/* File: dv/flash_device_model.sv */
// behavioural flash memory answering the host strobe pins
`timescale 1ns/1ps
module flash_device_model #(
    parameter logic [15:0] MAKER  = 16'h00a5, // arbitrary value
    parameter logic [15:0] DEVICE = 16'h005a, // arbitrary value
    parameter int          LAST   = 3
) (
    // host pins
    input  wire flash_host_pkg::pins_s pins,
    output logic [15:0]                flashDataIn,
    // test control and status
    input  wire logic                  stuck,
    output int                         progCount,
    output logic                       zeroedOk,
    output logic [7:0]                 mode
);
    logic [15:0] mem [16];
    logic [15:0] lat;
    logic [15:0] adr;
    logic [15:0] rd;
    logic [7:0]  prev;
    logic [7:0]  code;
    logic        pend;

    initial begin
        mode = 8'h00;
        prev = 8'h00;
        pend = 1'b0;
        lat = 16'h0000;
        adr = 16'h0000;
        progCount = 0;
        zeroedOk = 1'b1;
        foreach (mem[i]) mem[i] = 16'hffff;
    end

    // address taken on every fall, kept only by program data or erase verify
    always @(negedge pins.weN) if (!pins.selN) adr = pins.addr;

    // ============================================================
    // command register, sentinel 01h breaks two-cycle pairs
    always @(posedge pins.weN) begin
        if (!pins.selN && pins.oeN && pins.supplyHigh) begin
            code = pins.dataOut[7:0];
            if (pend) begin
                lat = adr;
                if (!stuck) mem[lat[3:0]] = mem[lat[3:0]] & pins.dataOut;
                progCount++;
                pend = 1'b0;
                code = 8'h01;
            end else begin
                if (code == 8'ha0) lat = adr;
                case (code)
                    8'h40: pend = 1'b1;
                    8'h20: if (prev == 8'h20) begin
                        for (int i = 0; i <= LAST; i++) if (mem[i] !== 16'h0000) zeroedOk = 1'b0;
                        foreach (mem[i]) mem[i] = 16'hffff;
                        code = 8'h01;
                    end
                    8'hff: if (prev == 8'hff) begin
                        mode = 8'h00;
                        code = 8'h01;
                    end
                    8'h00, 8'h90, 8'ha0, 8'hc0: mode = code;
                    default: ;
                endcase
            end
            prev = code;
        end
    end

    always_comb begin
        if (mode == 8'h90 && pins.addr[15:1] == 15'h0000) begin
            rd = pins.addr[0] ? DEVICE : MAKER;
        end
        else if (mode == 8'ha0 || mode == 8'hc0) rd = mem[lat[3:0]];
        else rd = mem[pins.addr[3:0]];
    end

    // released lines show the inverse, never a stale match
    assign flashDataIn = (!pins.selN && !pins.oeN && pins.weN) ? rd : ~rd;
endmodule : flash_device_model

/* File: dv/tb_flash_command_host.sv */
// self-checking bench for the flash command host
`timescale 1ns/1ps
module tb_flash_command_host;
    localparam logic [15:0] MAKER  = 16'h00a5; // arbitrary value
    localparam logic [15:0] DEVICE = 16'h005a; // arbitrary value
    logic                  clock    = 1'b0;
    logic                  rstn     = 1'b0;
    logic                  reqValid = 1'b0;
    logic                  stuck    = 1'b0;
    flash_host_pkg::req_s  req      = '0;
    logic                  reqReady;
    logic                  rspValid;
    flash_host_pkg::rsp_s  rsp;
    flash_host_pkg::pins_s pins;
    logic [15:0]           flashDataIn;
    logic                  zeroedOk;
    logic [7:0]            mode;
    int                    progCount;
    int                    n_errors = 0;
    int                    n_checks = 0;
    int                    cycles   = 0;

    always #4 clock = ~clock;

    flash_command_host #(.PROG_CYCLES(20), .ERASE_CYCLES(20), .RECOVER_CYCLES(20),
        .ERASE_LAST(3)) u_dut (
        .clock(clock), .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .rspValid(rspValid), .rsp(rsp), .pins(pins), .flashDataIn(flashDataIn));

    flash_device_model #(.MAKER(MAKER), .DEVICE(DEVICE), .LAST(3)) u_dev (
        .pins(pins), .flashDataIn(flashDataIn), .stuck(stuck), .progCount(progCount),
        .zeroedOk(zeroedOk), .mode(mode));

    // ============================================================
    // shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done;
        if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic do_op(input flash_host_pkg::op_e op, input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        reqValid <= 1'b1;
        req <= '{op, a, d};
        do @(posedge clock); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        do @(posedge clock); while (rspValid !== 1'b1);
    endtask : do_op

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("Error at %0t: timeout", $time);
            test_done();
        end
    end

    // ============================================================
    // scenarios
    task automatic t_idle;
        check({15'h0000, reqReady}, 16'h0001);
        check({13'h0000, pins.selN, pins.weN, pins.oeN}, 16'h0007);
        check({14'h0000, pins.dataOe, pins.supplyHigh}, 16'h0000);
    endtask : t_idle

    task automatic t_prog_read;
        do_op(flash_host_pkg::OP_PROGRAM, 16'h0005, 16'h1234);
        check({15'h0000, rsp.fail}, 16'h0000);
        check(16'(progCount), 16'h0001);
        do_op(flash_host_pkg::OP_READ, 16'h0005, 16'h0000);
        check(rsp.data, 16'h1234);
        do_op(flash_host_pkg::OP_READ, 16'h0006, 16'h0000);
        check(rsp.data, 16'hffff);
    endtask : t_prog_read

    task automatic t_ident;
        for (int i = 0; i < 2; i++) begin
            do_op(flash_host_pkg::OP_IDENT, 16'h8000 | 16'(i), 16'h0000);
            check(rsp.data, (i == 1) ? DEVICE : MAKER);
        end
    endtask : t_ident

    task automatic t_erase;
        do_op(flash_host_pkg::OP_ERASE, 16'h0000, 16'h0000);
        check({15'h0000, rsp.fail}, 16'h0000);
        check({15'h0000, zeroedOk}, 16'h0001);
        do_op(flash_host_pkg::OP_READ, 16'h0005, 16'h0000);
        check(rsp.data, 16'hffff);
    endtask : t_erase

    task automatic t_fail;
        int p0;
        p0 = progCount;
        stuck <= 1'b1;
        do_op(flash_host_pkg::OP_PROGRAM, 16'h0007, 16'h00f0);
        check({15'h0000, rsp.fail}, 16'h0001);
        check(16'(progCount - p0), 16'h0019);
        check({8'h00, mode}, 16'h0000);
        stuck <= 1'b0;
    endtask : t_fail

    task automatic t_reset;
        do_op(flash_host_pkg::OP_IDENT, 16'h0000, 16'h0000);
        do_op(flash_host_pkg::OP_RESET, 16'h0000, 16'h0000);
        check({8'h00, mode}, 16'h0000);
        do_op(flash_host_pkg::OP_READ, 16'h0005, 16'h0000);
        check(rsp.data, 16'hffff);
    endtask : t_reset

    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        t_idle();
        t_prog_read();
        t_ident();
        t_erase();
        t_fail();
        t_reset();
        test_done();
    end
endmodule : tb_flash_command_host

/* File: rtl/flash_command_host.sv */
// host controller that drives the flash memory over its strobe pins
`timescale 1ns/1ps
module flash_command_host #(
    parameter int PROG_CYCLES    = flash_host_pkg::PROG_CYC,
    parameter int ERASE_CYCLES   = flash_host_pkg::ERASE_CYC,
    parameter int RECOVER_CYCLES = flash_host_pkg::RECOVER_CYC,
    parameter int ERASE_LAST     = 16'hffff,
    parameter int MAX_LOOPS      = flash_host_pkg::MAX_LOOPS
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rstn,
    // user request
    input  wire logic                 reqValid,
    output logic                      reqReady,
    input  wire flash_host_pkg::req_s req,
    // user answer
    output logic                      rspValid,
    output flash_host_pkg::rsp_s      rsp,
    // flash pins
    output flash_host_pkg::pins_s     pins,
    input  wire logic [15:0]          flashDataIn
);

    // ============================================================
    // phases of one bus cycle and of each algorithm
    typedef enum logic [4:0] {
        S_IDLE,
        S_WR_LOW,
        S_WR_HIGH,
        S_RD_LOW,
        S_RD_END,
        S_WAIT,
        S_STEP,
        S_DONE
    } state_e;

    typedef enum logic [3:0] {
        A_READ0, A_READ1, A_ID0, A_ID1, A_PG0, A_PG1, A_PGV, A_PGC,
        A_ZP, A_ER0, A_ER1, A_EV, A_EVC, A_RS0, A_RS1
    } step_e;

    typedef struct packed {
        state_e                        st;
        step_e                         step;
        flash_host_pkg::req_s          cur;
        logic [15:0]                   walk;
        logic [flash_host_pkg::CNT_W-1:0] cnt;
        logic [7:0]                    loops;
        flash_host_pkg::pins_s         pins;
        flash_host_pkg::rsp_s          rsp;
        logic                          rspValid;
        logic [15:0]                   sample;
    } host_s;

    host_s state_ff;
    host_s nxt_state;

    // three-stage sampler; a new word counts once stages two and three agree
    logic [15:0] dinSync1_ff;
    logic [15:0] dinSync2_ff;
    logic [15:0] dinSync3_ff;
    logic [15:0] dinHeld_ff;

    function automatic logic [15:0] cmdWord(input logic [7:0] code);
        cmdWord = {flash_host_pkg::CMD_HI_BYTE, code};
    endfunction : cmdWord

    function automatic logic [flash_host_pkg::CNT_W-1:0] cyc(input int n);
        cyc = flash_host_pkg::CNT_W'(n);
    endfunction : cyc

    // word that a program cycle writes and that its verify read must return
    function automatic logic [15:0] progWord(input flash_host_pkg::req_s r);
        progWord = (r.op == flash_host_pkg::OP_ERASE) ? flash_host_pkg::ZERO_WORD : r.data;
    endfunction : progWord

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dinSync1_ff <= 16'h0000;
            dinSync2_ff <= 16'h0000;
            dinSync3_ff <= 16'h0000;
            dinHeld_ff  <= 16'h0000;
        end else begin
            dinSync1_ff <= flashDataIn;
            dinSync2_ff <= dinSync1_ff;
            dinSync3_ff <= dinSync2_ff;
            if (dinSync2_ff == dinSync3_ff) begin
                dinHeld_ff <= dinSync3_ff;
            end
        end
    end

    assign reqReady = (state_ff.st == S_IDLE);
    assign rspValid = state_ff.rspValid;
    assign rsp      = state_ff.rsp;
    assign pins     = state_ff.pins;

    // ============================================================
    // sequencer
    always_comb begin
        logic [7:0]  code;
        logic        isWrite;
        code      = 8'h00;
        isWrite   = 1'b0;
        nxt_state = state_ff;
        nxt_state.rspValid = 1'b0;
        case (state_ff.st)
            S_IDLE: begin
                nxt_state.pins.selN   = 1'b1;
                nxt_state.pins.oeN    = 1'b1;
                nxt_state.pins.weN    = 1'b1;
                nxt_state.pins.dataOe = 1'b0;
                if (reqValid) begin
                    nxt_state.cur   = req;
                    nxt_state.loops = 8'h00;
                    nxt_state.walk  = 16'h0000;
                    nxt_state.rsp.fail = 1'b0;
                    // supply rises one cycle ahead of the first strobe
                    nxt_state.pins.supplyHigh = 1'b1;
                    nxt_state.st    = S_STEP;
                    case (req.op)
                        flash_host_pkg::OP_READ:    nxt_state.step = A_READ0;
                        flash_host_pkg::OP_IDENT:   nxt_state.step = A_ID0;
                        flash_host_pkg::OP_PROGRAM: nxt_state.step = A_PG0;
                        flash_host_pkg::OP_ERASE:   nxt_state.step = A_ZP;
                        default:                    nxt_state.step = A_RS0;
                    endcase
                end
            end
            S_STEP: begin
                // choose the next bus cycle of the running algorithm
                isWrite = 1'b1;
                nxt_state.pins.addr = state_ff.cur.addr;
                case (state_ff.step)
                    A_READ0: code = flash_host_pkg::CMD_READ;
                    A_READ1: isWrite = 1'b0;
                    A_ID0:   code = flash_host_pkg::CMD_IDENT;
                    A_ID1: begin
                        isWrite = 1'b0;
                        // every other address line stays low for the identify read
                        nxt_state.pins.addr = state_ff.cur.addr[0] ?
                            flash_host_pkg::ADDR_DEVICE : flash_host_pkg::ADDR_MAKER;
                    end
                    A_PG0, A_ZP: code = flash_host_pkg::CMD_PROG;
                    A_PG1: begin
                        code = 8'h00;
                        nxt_state.pins.addr = (state_ff.cur.op == flash_host_pkg::OP_ERASE) ?
                            state_ff.walk : state_ff.cur.addr;
                    end
                    A_PGV:   code = flash_host_pkg::CMD_PRVFY;
                    A_PGC:   isWrite = 1'b0;
                    A_ER0, A_ER1: code = flash_host_pkg::CMD_ERASE;
                    A_EV: begin
                        code = flash_host_pkg::CMD_ERVFY;
                        nxt_state.pins.addr = state_ff.walk;
                    end
                    A_EVC:   isWrite = 1'b0;
                    default: code = flash_host_pkg::CMD_RESET;
                endcase
                nxt_state.pins.dataOut = cmdWord(code);
                if (state_ff.step == A_PG1) begin
                    nxt_state.pins.dataOut = progWord(state_ff.cur);
                end
                nxt_state.pins.selN = 1'b0;
                nxt_state.cnt = '0;
                if (isWrite) begin
                    nxt_state.pins.oeN    = 1'b1;
                    nxt_state.pins.weN    = 1'b0;
                    nxt_state.pins.dataOe = 1'b1;
                    nxt_state.st = S_WR_LOW;
                end else begin
                    nxt_state.pins.dataOe = 1'b0;
                    nxt_state.pins.oeN    = 1'b0;
                    nxt_state.st = S_RD_LOW;
                end
            end
            S_WR_LOW: begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
                if (state_ff.cnt >= cyc(flash_host_pkg::STROBE_CYC - 1)) begin
                    nxt_state.pins.weN = 1'b1;
                    nxt_state.cnt = '0;
                    nxt_state.st  = S_WR_HIGH;
                end
            end
            S_WR_HIGH: begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
                if (state_ff.cnt >= cyc(flash_host_pkg::STROBE_HI_CYC - 1)) begin
                    // data held past the strobe's rising edge until select rises
                    nxt_state.pins.dataOe = 1'b0;
                    nxt_state.pins.selN   = 1'b1;
                    nxt_state.cnt = '0;
                    nxt_state.st  = S_WAIT;
                end
            end
            S_WAIT: begin
                // pulse time for program and erase, recovery before any read
                nxt_state.cnt = state_ff.cnt + 1'b1;
                if ((state_ff.step == A_ER1 && state_ff.cnt >= cyc(ERASE_CYCLES)) ||
                    (state_ff.step == A_PG1 && state_ff.cnt >= cyc(PROG_CYCLES)) ||
                    (state_ff.step != A_ER1 && state_ff.step != A_PG1 &&
                     state_ff.cnt >= cyc(RECOVER_CYCLES))) begin
                    nxt_state.cnt = '0;
                    nxt_state.st  = S_STEP;
                    case (state_ff.step)
                        A_READ0: nxt_state.step = A_READ1;
                        A_ID0:   nxt_state.step = A_ID1;
                        A_PG0, A_ZP: nxt_state.step = A_PG1;
                        A_PG1:   nxt_state.step = A_PGV;
                        A_PGV:   nxt_state.step = A_PGC;
                        A_ER0:   nxt_state.step = A_ER1;
                        A_ER1:   nxt_state.step = A_EV;
                        A_EV:    nxt_state.step = A_EVC;
                        A_RS0:   nxt_state.step = A_RS1;
                        default: nxt_state.st = S_DONE;
                    endcase
                end
            end
            S_RD_LOW: begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
                // sample well after the access time so the sampler has caught up
                if (state_ff.cnt >= cyc(flash_host_pkg::ACCESS_CYC + 3)) begin
                    nxt_state.sample   = dinHeld_ff;
                    nxt_state.pins.oeN  = 1'b1;
                    nxt_state.pins.selN = 1'b1;
                    nxt_state.cnt = '0;
                    nxt_state.st  = S_RD_END;
                end
            end
            S_RD_END: begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
                // let the device release the data lines first
                if (state_ff.cnt >= cyc(flash_host_pkg::FLOAT_CYC)) begin
                    nxt_state.st = S_STEP;
                    case (state_ff.step)
                        A_PGC: begin
                            if (state_ff.sample == progWord(state_ff.cur)) begin
                                nxt_state.loops = 8'h00;
                                // erase zeroes each word in turn; a plain program ends here
                                if (state_ff.cur.op != flash_host_pkg::OP_ERASE) begin
                                    nxt_state.st = S_DONE;
                                end else if (state_ff.walk == 16'(ERASE_LAST)) begin
                                    nxt_state.walk = 16'h0000;
                                    nxt_state.step = A_ER0;
                                end else begin
                                    nxt_state.walk = state_ff.walk + 1'b1;
                                    nxt_state.step = A_ZP;
                                end
                            end else if (state_ff.loops >= 8'(MAX_LOOPS - 1)) begin
                                nxt_state.rsp.fail = 1'b1;
                                nxt_state.step = A_RS0;
                            end else begin
                                nxt_state.loops = state_ff.loops + 1'b1;
                                nxt_state.step = A_PG0;
                                if (state_ff.cur.op == flash_host_pkg::OP_ERASE) begin
                                    nxt_state.step = A_ZP;
                                end
                            end
                        end
                        A_EVC: begin
                            // a word still programmed sends the erase round again, verify resuming at that word
                            if (state_ff.sample != flash_host_pkg::ERASED_WORD) begin
                                nxt_state.loops = state_ff.loops + 1'b1;
                                nxt_state.step  = A_ER0;
                                if (state_ff.loops >= 8'(MAX_LOOPS - 1)) begin
                                    nxt_state.rsp.fail = 1'b1;
                                    nxt_state.step = A_RS0;
                                end
                            end else if (state_ff.walk == 16'(ERASE_LAST)) begin
                                nxt_state.st = S_DONE;
                            end else begin
                                nxt_state.walk = state_ff.walk + 1'b1;
                                nxt_state.step = A_EV;
                            end
                        end
                        default: nxt_state.st = S_DONE;
                    endcase
                end
            end
            default: begin
                nxt_state.rsp.data = state_ff.sample;
                nxt_state.rspValid = 1'b1;
                // program supply stays low between operations
                nxt_state.pins.supplyHigh = 1'b0;
                nxt_state.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '{st: S_IDLE, step: A_READ0, cur: '0, walk: 16'h0000, cnt: '0,
                          loops: 8'h00,
                          pins: '{selN: 1'b1, oeN: 1'b1, weN: 1'b1, supplyHigh: 1'b0,
                                  addr: 16'h0000, dataOut: 16'h0000, dataOe: 1'b0},
                          rsp: '0, rspValid: 1'b0, sample: 16'h0000};
        end else begin
            state_ff <= nxt_state;
        end
    end

endmodule : flash_command_host

/* File: rtl/flash_host_pkg.sv */
// constants, commands and carriers for the flash command host
// ============================================================
// Behaviour
// - write set-read before array reads at high supply
// - identify then word 0 maker, word 1 device
// - identify also via high-voltage id_select flag; the host has no such pin and identifies only by the 90h command
// - erase needs two consecutive 20h writes
// - erase verify: A0h write with address, then read
// - program: 40h write, then address and data write
// - reset is two consecutive FFh writes
// - wait 6 us after strobe rise before read
// - retry program at most 25 loops
// - program all zero before erase
package flash_host_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int CLK_MHZ = 125;

    // ============================================================
    // command codes (low byte only)
    localparam logic [7:0] CMD_READ    = 8'h00;
    localparam logic [7:0] CMD_IDENT   = 8'h90;
    localparam logic [7:0] CMD_ERASE   = 8'h20;
    localparam logic [7:0] CMD_ERVFY   = 8'ha0;
    localparam logic [7:0] CMD_PROG    = 8'h40;
    localparam logic [7:0] CMD_PRVFY   = 8'hc0;
    localparam logic [7:0] CMD_RESET   = 8'hff;
    localparam logic [7:0] CMD_HI_BYTE = 8'h00;

    // ============================================================
    // timing in ns, and cycle counts rounded up
    localparam int T_STROBE_NS   = 40;
    localparam int T_STROBE_HI_NS = 20;
    localparam int T_ACCESS_NS   = 200;
    localparam int T_PROG_NS     = 10000;
    localparam int T_ERASE_NS    = 9500000;
    localparam int T_RECOVER_NS  = 6000;
    localparam int T_FLOAT_NS    = 45;
    localparam int PERIOD_NS     = 1000 / CLK_MHZ;
    localparam int STROBE_CYC    = (T_STROBE_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int STROBE_HI_CYC = (T_STROBE_HI_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int ACCESS_CYC    = (T_ACCESS_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int PROG_CYC      = (T_PROG_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int ERASE_CYC     = (T_ERASE_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int RECOVER_CYC   = (T_RECOVER_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int FLOAT_CYC     = (T_FLOAT_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int MAX_LOOPS     = 25;
    localparam int CNT_W         = 24;

    localparam logic [ADDR_W-1:0] ADDR_MAKER  = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_DEVICE = 16'h0001;
    localparam logic [DATA_W-1:0] ZERO_WORD   = 16'h0000;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

    // ============================================================
    // user operations
    typedef enum logic [2:0] {
        OP_READ,
        OP_IDENT,
        OP_PROGRAM,
        OP_ERASE,
        OP_RESET
    } op_e;

    typedef struct packed {
        op_e               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              fail;
    } rsp_s;

    typedef struct packed {
        logic              selN;
        logic              oeN;
        logic              weN;
        logic              supplyHigh;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dataOut;
        logic              dataOe;
    } pins_s;

endpackage : flash_host_pkg
